// file: bench/led_serial_cfg_test.sv
/*
 Self-checking bench for led_serial_cfg: the host model drives the link,
 the bench drives pins and queues expected values for the monitor.
 Assumes the package and design modules are compiled first.
*/
`timescale 1ns/1ps
`define CHECK(g, e) begin got_q.push_back(192'(g)); exp_q.push_back(192'(e)); end
module led_serial_cfg_test
  import led_cfg_pkg::*;
;
  logic         mclk  = 1'b0;
  logic         rst_n = 1'b0;
  logic         sclk, serial_input, lat, serial_chain_output, err_o, err_oe, clr;
  logic [1:0]   mode  = 2'h1;
  logic         ssel  = 1'b1;
  logic         kill  = 1'b0;
  logic         therm = 1'b0;
  logic [15:0]  drive = 16'h0;
  logic [15:0]  sense = 16'h0;
  logic [15:0]  chan;
  logic [191:0] gs, st, d;
  logic [95:0]  dc, dcv;
  logic [193:0] rv;
  logic [191:0] got_q[$];
  logic [191:0] exp_q[$];
  int           num_errors  = 0;
  int           checks_done = 0;

  always #5 mclk = ~mclk;

  serial_host p_u (.o_shift_clk(sclk), .o_serial(serial_input), .o_latch(lat), .i_chain(serial_chain_output));

  led_serial_cfg dut_u (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_shift_clk(sclk), .i_serial_input(serial_input),
    .i_latch_strobe(lat), .i_mode_select_pin(mode), .i_store_select(ssel),
    .i_output_kill(kill), .i_thermal_flag(therm), .i_channel_drive(drive),
    .i_channel_sense_low(sense), .o_serial_chain_output(serial_chain_output),
    .o_error_output_n_o(err_o), .o_error_output_n_oe(err_oe),
    .o_channel_output(chan), .o_grayscale(gs), .o_dot_correction(dc),
    .o_gs_count_clear(clr)
  );

  // Oldest note is paired with the oldest observation
  always @(posedge mclk) begin
    while (got_q.size() > 0) begin
      checks_done++;
      if (got_q[0] !== exp_q[0]) begin
        num_errors++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic end_sim();
    tick(2);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  initial begin
    #200us;
    num_errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h3514f7ae));
    // Shift domain needs its own edges while reset is low
    fork
      p_u.xfer('0, 3, rv);
      tick(8);
    join
    tick(1);
    rst_n = 1'b1;
    tick(3);
    // Shift side leaves reset two shift edges later
    p_u.xfer('0, 2, rv);
    // Dot-correction load first, so mode is defined
    for (int i = 0; i < 3; i++) d[i*32 +: 32] = $urandom;
    dcv = d[95:0];
    p_u.xfer({98'h0, dcv}, 96, rv);
    `CHECK(rv, {191'h0, dcv[95]})
    p_u.latch();
    tick(4);
    `CHECK(dc, dcv)
    // Store write: programming level first, then store-select rise
    ssel = 1'b0;
    tick(4);
    mode = 2'h2;
    tick(4);
    p_u.latch();
    `CHECK(gs, 192'h0)
    ssel = 1'b1;
    tick(6);
    ssel = 1'b0;
    mode = 2'h0;
    tick(6);
    `CHECK(dc, dcv)
    // Staggered switch-on, then open sampling
    sense = 16'($urandom) | 16'h1;
    tick(4);
    drive = 16'hffff;
    st = '0;
    for (int k = 1; k < 34; k++) begin
      tick(1);
      for (int n = 0; n < 16; n++) st[n] = (k >= 2 + 2 * n);
      `CHECK(chan, st[15:0])
    end
    `CHECK(err_oe, 1'b0)
    tick(140);
    `CHECK({err_oe, err_o}, 2'h2)
    // Grayscale load with thermal flag up
    therm = 1'b1;
    for (int i = 0; i < 6; i++) d[i*32 +: 32] = $urandom;
    p_u.xfer({2'h0, d}, 192, rv);
    `CHECK(rv[0], d[191])
    p_u.latch();
    tick(4);
    `CHECK(gs, d)
    // Extra pulses after the latch, then status read back
    p_u.xfer('0, 194, rv);
    st = '0;
    st[191:176] = sense;
    st[175] = 1'b1;
    st[167:72] = dcv;
    `CHECK(rv[191:0], st)
    // Kill: outputs off, counter cleared, open masked
    therm = 1'b0;
    kill = 1'b1;
    tick(5);
    `CHECK({chan, clr, err_oe}, {16'h0, 2'h2})
    therm = 1'b1;
    tick(5);
    `CHECK(err_oe, 1'b1)
    therm = 1'b0;
    kill = 1'b0;
    tick(40);
    `CHECK({chan, clr}, {16'hffff, 1'b0})
    end_sim();
  end
endmodule : led_serial_cfg_test

// file: bench/serial_host.sv
/*
 Controller model on the far side of the serial link: drives shift clock,
 serial data and latch strobe, and samples the chain output.
 Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module serial_host (
  output logic      o_shift_clk,
  output logic      o_serial,
  output logic      o_latch,
  input  wire logic i_chain
);
  initial begin
    o_shift_clk = 1'b0;
    o_serial    = 1'b0;
    o_latch     = 1'b0;
  end

  // Clock rests low between frames; r[i] is the chain bit after edge i
  task automatic xfer(input logic [193:0] d, input int n, output logic [193:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial = d[i];
      #24 o_shift_clk = 1'b1;
      #2 r[i] = i_chain;
      #22 o_shift_clk = 1'b0;
    end
    // Idle line must not keep the last bit
    o_serial = ~o_serial;
  endtask : xfer

  // Strobe held 6 system cycles, well past the synchroniser
  task automatic latch();
    #30 o_latch = 1'b1;
    #60 o_latch = 1'b0;
    #60;
  endtask : latch
endmodule : serial_host

// file: design/channel_stage.sv
/*
 One output channel: staggered switching delay, kill gating and
 open-LED sampling a fixed time after switch-on.
 Assumes i_kill and i_sense_low are already synchronised.
*/
`timescale 1ns/1ps
module channel_stage
  import led_cfg_pkg::*;
#(
  parameter int DLY = 0
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_drive,
  input  wire logic i_kill,
  input  wire logic i_sense_low,
  output logic      o_output,
  output logic      o_open
);
  logic [DLY:0]            pipe_q, pipe_d;
  logic [DLY+1:0]          pipe_ext;
  logic                    out_d, open_d;
  logic [OPEN_CNT_W-1:0]   cnt_q, cnt_d;

  always_comb begin
    pipe_ext = {pipe_q, i_drive};
    pipe_d   = pipe_ext[DLY:0];
    out_d    = pipe_q[DLY] & ~i_kill;
    cnt_d    = cnt_q;
    open_d   = o_open;
    if (!o_output) begin
      cnt_d = '0;
    end else if (cnt_q != OPEN_CNT_END) begin
      cnt_d = cnt_q + OPEN_CNT_W'(1);
      if (cnt_d == OPEN_CNT_END) begin
        open_d = i_sense_low;
      end
    end
    if (i_kill) begin
      open_d = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pipe_q   <= '0;
      o_output <= 1'b0;
      o_open   <= 1'b0;
      cnt_q    <= '0;
    end else begin
      pipe_q   <= pipe_d;
      o_output <= out_d;
      o_open   <= open_d;
      cnt_q    <= cnt_d;
    end
  end

  a_open_sample: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_output && cnt_q == OPEN_CNT_END - OPEN_CNT_W'(1) && !i_kill
    |=> o_open == $past(i_sense_low))
    else $error("open flag not sampled at switch-on plus 1 us");
endmodule : channel_stage

// file: design/dc_store.sv
/*
 Non-volatile dot-correction store model: sixteen 6-bit words written
 all at once, read back as one registered 96-bit word.
 Assumes write pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
module dc_store
  import led_cfg_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wr,
  input  wire logic [DC_LEN-1:0] i_wdata,
  output logic      [DC_LEN-1:0] o_rdata
);
  logic [DC_BITS-1:0] mem_q [CHANNELS];
  logic [DC_LEN-1:0]  rd_d;

  always_comb begin
    for (int i = 0; i < CHANNELS; i++) begin
      rd_d[i*DC_BITS +: DC_BITS] = mem_q[i];
    end
  end

  // Contents survive reset, as a real store would
  always_ff @(posedge i_mclk) begin
    if (i_wr) begin
      for (int i = 0; i < CHANNELS; i++) begin
        mem_q[i] <= i_wdata[i*DC_BITS +: DC_BITS];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rd_d;
    end
  end
endmodule : dc_store

// file: design/led_cfg_pkg.sv
/*
 Constants of the LED driver serial configuration block: packet sizes,
 status field positions, mode pin codes and timing counts.
 Assumes a 100 MHz system clock.
*/
package led_cfg_pkg;
  localparam int CHANNELS       = 16;
  localparam int DC_BITS        = 6;
  localparam int GS_BITS        = 12;
  localparam int DC_LEN         = 96;
  localparam int GS_LEN         = 192;
  // Status packet field positions
  localparam int ST_OPEN_LSB    = 176;
  localparam int ST_THERM_BIT   = 175;
  localparam int ST_DC_LSB      = 72;
  localparam int ST_DC_MSB      = 167;
  // Mode pin levels, encoded by the pad comparator
  localparam logic [1:0] MODE_GND  = 2'h0;
  localparam logic [1:0] MODE_VCC  = 2'h1;
  localparam logic [1:0] MODE_PROG = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int CHAN_DELAY_NS  = 20;
  localparam int OPEN_SAMPLE_NS = 1000;
  localparam int CHAN_DELAY_CYC =
    (CHAN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_SAMPLE_CYC =
    (OPEN_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OPEN_CNT_W     = 7;
  localparam logic [OPEN_CNT_W-1:0] OPEN_CNT_END = OPEN_CNT_W'(OPEN_SAMPLE_CYC);
  // Pins synchronised into the system clock
  localparam int SYNC_W         = 6 + CHANNELS;
endpackage : led_cfg_pkg

// file: design/led_serial_cfg.sv
/*
 Serial configuration and control of a 16-channel LED driver: shift
 register on the shift clock, latching into dot-correction and grayscale
 registers, status readback, error output, kill and staggered outputs.
 Assumes the shift clock is idle while the latch strobe is high, so the
 shift register is stable when sampled on the system clock.
*/
`timescale 1ns/1ps
module led_serial_cfg
  import led_cfg_pkg::*;
(
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  input  wire logic                i_shift_clk,
  input  wire logic                i_serial_input,
  input  wire logic                i_latch_strobe,
  input  wire logic [1:0]          i_mode_select_pin,
  input  wire logic                i_store_select,
  input  wire logic                i_output_kill,
  input  wire logic                i_thermal_flag,
  input  wire logic [CHANNELS-1:0] i_channel_drive,
  input  wire logic [CHANNELS-1:0] i_channel_sense_low,
  output logic                     o_serial_chain_output,
  output logic                     o_error_output_n_o,
  output logic                     o_error_output_n_oe,
  output logic [CHANNELS-1:0]      o_channel_output,
  output logic [GS_LEN-1:0]        o_grayscale,
  output logic [DC_LEN-1:0]        o_dot_correction,
  output logic                     o_gs_count_clear
);
  // System clock side: pin synchronisers
  logic [SYNC_W-1:0]   meta_q, sync_q;
  logic                latch_s, store_s, kill_s, therm_s;
  logic [1:0]          mode_s;
  logic [CHANNELS-1:0] sense_s;
  logic                latch_prev_q, store_prev_q;
  logic                latch_rise, store_rise;

  always_ff @(posedge i_mclk) begin
    meta_q <= {i_latch_strobe, i_mode_select_pin, i_store_select,
               i_output_kill, i_thermal_flag, i_channel_sense_low};
    sync_q <= meta_q;
  end

  always_comb begin
    {latch_s, mode_s, store_s, kill_s, therm_s, sense_s} = sync_q;
    latch_rise = latch_s & ~latch_prev_q;
    store_rise = store_s & ~store_prev_q;
  end

  // Shift clock side: registers and crossings
  logic              srst_meta_q, srst_n_q;
  logic [1:0]        smode_meta_q, smode_q;
  logic              tog_meta_q, tog_q, tog_seen_q, tog_seen_d;
  logic [GS_LEN-1:0] shift_q, shift_d;
  logic              serial_chain_output_d, sload;

  // System clock state
  logic [DC_LEN-1:0]   dc_reg_q, dc_reg_d;
  logic [GS_LEN-1:0]   gs_q, gs_d;
  logic [GS_LEN-1:0]   status_q, status_d;
  logic                status_tog_q, status_tog_d;
  logic                err_d, clr_d;
  logic [DC_LEN-1:0]   dc_sel, dcout_d;
  logic [DC_LEN-1:0]   nv_rdata;
  logic                nv_wr;
  logic                gs_latch, dc_latch;
  logic [CHANNELS-1:0] open_flags;

  always_comb begin
    gs_latch = latch_rise && mode_s == MODE_GND;
    dc_latch = latch_rise && mode_s == MODE_VCC;
    nv_wr    = store_rise && mode_s == MODE_PROG;
    dc_sel   = store_s ? dc_reg_q : nv_rdata;
    dc_reg_d = dc_reg_q;
    gs_d     = gs_q;
    status_d = status_q;
    status_tog_d = status_tog_q;
    // Shift register is quiet while the strobe is high
    if (dc_latch) begin
      dc_reg_d = shift_q[DC_LEN-1:0];
    end
    if (gs_latch) begin
      gs_d = shift_q;
      status_d = '0;
      status_d[ST_OPEN_LSB +: CHANNELS] = open_flags;
      status_d[ST_THERM_BIT] = therm_s;
      status_d[ST_DC_MSB:ST_DC_LSB] = dc_sel;
      status_tog_d = ~status_tog_q;
    end
    err_d   = therm_s | ((|open_flags) & ~kill_s);
    clr_d   = kill_s;
    dcout_d = dc_sel;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      // High, so a pin already high at release is not taken as an edge
      latch_prev_q        <= 1'b1;
      store_prev_q        <= 1'b1;
      dc_reg_q            <= '0;
      gs_q                <= '0;
      status_q            <= '0;
      status_tog_q        <= 1'b0;
      o_error_output_n_oe <= 1'b0;
      o_gs_count_clear    <= 1'b0;
      o_dot_correction    <= '0;
    end else begin
      latch_prev_q        <= latch_s;
      store_prev_q        <= store_s;
      dc_reg_q            <= dc_reg_d;
      gs_q                <= gs_d;
      status_q            <= status_d;
      status_tog_q        <= status_tog_d;
      o_error_output_n_oe <= err_d;
      o_gs_count_clear    <= clr_d;
      o_dot_correction    <= dcout_d;
    end
  end

  always_comb begin
    o_error_output_n_o = 1'b0; // Open drain: only ever pulls low
    o_grayscale        = gs_q;
  end

  dc_store u_store (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_wr    (nv_wr),
    .i_wdata (dc_reg_q),
    .o_rdata (nv_rdata)
  );

  for (genvar n = 0; n < CHANNELS; n++) begin : g_chan
    channel_stage #(
      .DLY (n * CHAN_DELAY_CYC)
    ) u_stage (
      .i_mclk      (i_mclk),
      .i_rst_n     (i_rst_n),
      .i_drive     (i_channel_drive[n]),
      .i_kill      (kill_s),
      .i_sense_low (sense_s[n]),
      .o_output    (o_channel_output[n]),
      .o_open      (open_flags[n])
    );
  end

  // Shift clock domain. Reset and mode are level crossings; the status
  // word is held stable in status_q and announced by a toggle.
  always_ff @(posedge i_shift_clk) begin
    srst_meta_q  <= i_rst_n;
    srst_n_q     <= srst_meta_q;
    smode_meta_q <= i_mode_select_pin;
    smode_q      <= smode_meta_q;
    tog_meta_q   <= status_tog_q;
    tog_q        <= tog_meta_q;
  end

  // Status load costs the two synchroniser edges; the controller gives
  // extra pulses after a grayscale latch to cover them.
  always_comb begin
    sload      = tog_q != tog_seen_q;
    tog_seen_d = tog_q;
    if (sload) begin
      shift_d = status_q;
    end else begin
      shift_d = {shift_q[GS_LEN-2:0], i_serial_input};
    end
    if (smode_q == MODE_GND) begin
      serial_chain_output_d = shift_d[GS_LEN-1];
    end else begin
      serial_chain_output_d = shift_d[DC_LEN-1];
    end
  end

  always_ff @(posedge i_shift_clk) begin
    if (!srst_n_q) begin
      shift_q               <= '0;
      tog_seen_q            <= 1'b0;
      o_serial_chain_output <= 1'b0;
    end else begin
      shift_q               <= shift_d;
      tog_seen_q            <= tog_seen_d;
      o_serial_chain_output <= serial_chain_output_d;
    end
  end

  // Checks on the shift clock
  a_shift_in: assert property (@(posedge i_shift_clk) disable iff (!srst_n_q)
    !sload |=> shift_q[0] == $past(i_serial_input))
    else $error("serial input bit not shifted in");

  a_chain_msb: assert property (@(posedge i_shift_clk) disable iff (!srst_n_q)
    smode_q == MODE_GND |=> o_serial_chain_output == shift_q[GS_LEN-1])
    else $error("chain output is not shift register msb");

  a_status_load: assert property (@(posedge i_shift_clk) disable iff (!srst_n_q)
    sload |=> shift_q == $past(status_q))
    else $error("status packet not loaded into shift register");

  a_chain_dc: assert property (@(posedge i_shift_clk) disable iff (!srst_n_q)
    smode_q != MODE_GND |=> o_serial_chain_output == shift_q[DC_LEN-1])
    else $error("chain output is not bit 95 in dot-correction mode");

  a_sload_once: assert property (@(posedge i_shift_clk) disable iff (!srst_n_q)
    sload |=> !sload)
    else $error("status packet loaded twice for one latch");

  // Checks on the system clock
  a_err_thermal: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    therm_s |=> o_error_output_n_oe && !o_error_output_n_o)
    else $error("thermal flag did not pull error low");

  a_err_masked: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    kill_s && !therm_s |=> !o_error_output_n_oe)
    else $error("open flag not masked while kill high");

  a_err_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !kill_s && (|open_flags) |=> o_error_output_n_oe)
    else $error("open flag did not pull error low");

  a_err_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !therm_s && !(|open_flags) |=> !o_error_output_n_oe)
    else $error("error output pulled low without a flag");

  a_clear_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !kill_s |=> !o_gs_count_clear)
    else $error("grayscale counter cleared while kill low");

  a_kill_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    kill_s |=> open_flags == '0)
    else $error("open flag kept while kill high");

  a_gs_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !gs_latch |=> $stable(gs_q))
    else $error("grayscale register changed without a latch");

  a_dc_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !dc_latch |=> $stable(dc_reg_q))
    else $error("dot-correction register changed without a latch");

  a_status_open: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gs_latch |=> status_q[ST_OPEN_LSB +: CHANNELS] == $past(open_flags))
    else $error("status open bits wrong");

  a_status_dc: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gs_latch |=> status_q[ST_DC_MSB:ST_DC_LSB] == $past(dc_sel))
    else $error("status dot-correction field wrong");

  a_status_rsvd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gs_latch |=> status_q[ST_DC_LSB-1:0] == '0
      && status_q[ST_THERM_BIT-1:ST_DC_MSB+1] == '0)
    else $error("status reserved bits not zero");

  a_dc_out: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    store_s |=> o_dot_correction == $past(dc_reg_q))
    else $error("active dot-correction not taken from register");

  a_dc_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    dc_latch |=> dc_reg_q == $past(shift_q[DC_LEN-1:0]) && $stable(gs_q))
    else $error("dot-correction latch wrong");

  a_gs_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    gs_latch |=> o_grayscale == $past(shift_q) && status_q[ST_THERM_BIT] == $past(therm_s))
    else $error("grayscale latch or status thermal bit wrong");

  a_prog_latch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    latch_rise && mode_s == MODE_PROG |=> $stable(gs_q) && $stable(dc_reg_q))
    else $error("latch acted in programming mode");

  a_store_write: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    nv_wr ##1 !nv_wr |=> nv_rdata == $past(dc_reg_q, 2))
    else $error("store did not take dot-correction register");

  a_kill_off: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    kill_s |=> o_channel_output == '0 && o_gs_count_clear)
    else $error("kill did not force outputs off");

  a_stagger: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(i_channel_drive[1:0], 3) inside {2'b00, 2'b11} && !kill_s && !$past(kill_s, 2)
    |=> o_channel_output[1] == $past(o_channel_output[0], CHAN_DELAY_CYC))
    else $error("channel one not delayed 20 ns after channel zero");
endmodule : led_serial_cfg
